// >>> rtl/vdc_mem_engines.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Byte FIFO between move reads and move writes
module move_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_sys,
    input  wire logic                       clr,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("move_fifo depth must be a power of two");
    end
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];
    assign level     = cnt_r;
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_r + AW'(push);
            rp_r  <= rp_r + AW'(pop);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // move_fifo

// ==========================================
// Walks one rectangle, byte by byte, line by line
module block_walker (
    input  wire logic                          clk_sys,
    input  wire logic                          clr,
    input  wire logic                          load,
    input  wire logic                          step,
    input  wire logic                          reverse,
    input  wire logic [vdc_pkg::ADDR_W-1:0]    start,
    input  wire logic [vdc_pkg::LEN_W-1:0]     len,
    input  wire logic [vdc_pkg::LINES_W-1:0]   lines,
    input  wire logic [vdc_pkg::SKIP_W-1:0]    skip,
    output logic [vdc_pkg::ADDR_W-1:0]         addr,
    output logic                               active
);
    logic [vdc_pkg::ADDR_W-1:0]  line_r;
    logic [vdc_pkg::LEN_W-1:0]   off_r;
    logic [vdc_pkg::LINES_W-1:0] left_r;
    logic                        act_r;
    wire line_end = off_r == len - 8'h01;
    wire [vdc_pkg::ADDR_W-1:0] skip_x = vdc_pkg::ADDR_W'(skip);
    wire [vdc_pkg::ADDR_W-1:0] off_x  = vdc_pkg::ADDR_W'(off_r);
    assign addr   = reverse ? line_r - off_x : line_r + off_x;
    assign active = act_r;
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            line_r <= vdc_pkg::ADDR_RST;
            off_r  <= '0;
            left_r <= '0;
            act_r  <= 1'b0;
        end else if (load) begin
            line_r <= start;
            off_r  <= '0;
            left_r <= lines;
            act_r  <= len != '0 && lines != '0;
        end else if (step && act_r) begin
            if (line_end) begin
                off_r  <= '0;
                line_r <= reverse ? line_r - skip_x : line_r + skip_x;
                left_r <= left_r - 9'h001;
                act_r  <= left_r != 9'h001;
            end else begin
                off_r <= off_r + 8'h01;
            end
        end
    end
endmodule // block_walker

// What this block does
// - Line length 0 to 255 bytes
// - Block lines 1 to 256
// - Lines spaced by skip, 1 to 2048
// - Source start is 17-bit first byte
// - Destination start is 17-bit first write
// - Shape write loads length, lines, skip
// - Address write loads source and destination
// - Direction bit; reverse uses last addresses
// - One start command after parameters
// - Four bytes per five pixel clocks
// - Display and host accesses win memory
// - Raw mode bypasses modulator, 8-bit unsigned
// - Samples ascend from base shifted left
// - Line length sets buffer, 1 to 4096
// - Sample drives DAC upper bits, LSB zero
// - First 10 cycles of line hold DAC
// - Run, mode, bias, divider controls used
// - Host may write memory while running
// - Video reset asynchronous, three-cycle exit
// - Video reset keeps control registers
// - Table select uses table U and V inside picture area
// - Table U zero-extended, V plain
module vdc_mem_engines (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          video_reset_n,
    input  wire logic                          move_address_param_write,
    input  wire vdc_pkg::move_addr_t           move_addr_param,
    input  wire logic                          move_shape_param_write,
    input  wire vdc_pkg::move_shape_t          move_shape_param,
    input  wire logic                          move_reverse,
    input  wire logic                          move_start,
    output logic                               move_busy,
    input  wire logic                          host_mem_busy,
    input  wire logic                          disp_fetch_busy,
    output vdc_pkg::mem_rd_t                   mem_rd,
    input  wire logic [vdc_pkg::BYTE_W-1:0]    mem_rd_data,
    output vdc_pkg::mem_wr_t                   mem_wr,
    input  wire logic                          controller_run_bit,
    input  wire logic                          raw_sample_mode_select,
    input  wire logic                          analog_bias_on,
    input  wire logic [vdc_pkg::DIV_W-1:0]     sample_rate_divider,
    input  wire logic [vdc_pkg::BASE_W-1:0]    buffer_base,
    input  wire logic [vdc_pkg::LLEN_W-1:0]    line_length,
    input  wire logic                          line_start,
    input  wire logic [vdc_pkg::DAC_W-1:0]     mod_sample,
    output logic                               modulator_bypass,
    output logic                               dac_bias_en,
    output logic [vdc_pkg::DAC_W-1:0]          dac_code,
    input  wire logic                          table_chroma_select,
    input  wire logic                          picture_area,
    input  wire logic [3:0]                    u_table_bits,
    input  wire logic [3:0]                    v_table,
    input  wire logic [5:0]                    pixel_u,
    input  wire logic [3:0]                    pixel_v,
    output logic [5:0]                         chroma_u,
    output logic [3:0]                         chroma_v
);
    localparam int FD = vdc_pkg::FIFO_DEPTH;
    // ==========================================
    // Video reset: immediate entry, three-edge exit
    logic [vdc_pkg::RESET_EXIT_CYCLES-1:0] vchain_r;
    always_ff @(posedge clk_sys or negedge video_reset_n) begin
        if (!video_reset_n) begin
            vchain_r <= '0;
        end else begin
            vchain_r <= {vchain_r[vdc_pkg::RESET_EXIT_CYCLES-2:0], 1'b1};
        end
    end
    wire vclr = rst || !vchain_r[vdc_pkg::RESET_EXIT_CYCLES-1];

    // ==========================================
    // Move parameters; live with the host port, so video reset leaves them
    vdc_pkg::move_addr_t  addr_r;
    vdc_pkg::move_shape_t shape_r;
    logic                 rev_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_r  <= '0;
            shape_r <= '0;
            rev_r   <= 1'b0;
        end else begin
            if (move_address_param_write) begin
                addr_r <= move_addr_param;
            end
            if (move_shape_param_write) begin
                shape_r <= move_shape_param;
            end
            if (move_start && !move_busy) begin
                rev_r <= move_reverse;
            end
        end
    end

    // ==========================================
    // Arbitration: host and display first, raw samples over the move
    logic                              busy_r;
    logic [2:0]                        slot_r;
    logic                              rd_pend_r;
    logic                              dac_pend_r;
    logic                              dac_want_r;
    logic [vdc_pkg::ADDR_W-1:0]        src_addr;
    logic [vdc_pkg::ADDR_W-1:0]        dst_addr;
    logic                              src_act;
    logic                              dst_act;
    logic                              f_in_ready;
    logic                              f_out_valid;
    logic [vdc_pkg::BYTE_W-1:0]        f_out_data;
    logic [$clog2(FD):0]               f_level;
    logic [vdc_pkg::LLEN_W-1:0]        idx_r;

    wire mem_free    = !host_mem_busy && !disp_fetch_busy;
    wire slot_ok     = slot_r != 3'(vdc_pkg::PACE_BYTES);
    wire fifo_room   = f_level <= ($clog2(FD)+1)'(FD - 2);
    wire dac_rd_go   = dac_want_r && mem_free;
    wire mv_rd_go    = src_act && slot_ok && mem_free && !dac_want_r && fifo_room;
    wire mv_wr_go    = f_out_valid && mem_free;
    wire move_load   = move_start && !busy_r;
    wire move_done   = busy_r && !src_act && !dst_act && !f_out_valid && !rd_pend_r;
    wire [vdc_pkg::ADDR_W-1:0] dac_addr =
        {buffer_base, 1'b0} + vdc_pkg::ADDR_W'(idx_r);

    // Requests and busy drop the moment the pin goes low, not at the next edge
    assign mem_rd.req  = !vclr && (mv_rd_go || dac_rd_go);
    assign mem_rd.addr = dac_rd_go ? dac_addr : src_addr;
    assign mem_wr.req  = !vclr && mv_wr_go;
    assign mem_wr.addr = dst_addr;
    assign mem_wr.data = f_out_data;
    assign move_busy   = busy_r && !vclr;

    always_ff @(posedge clk_sys) begin
        if (vclr) begin
            busy_r     <= 1'b0;
            slot_r     <= '0;
            rd_pend_r  <= 1'b0;
            dac_pend_r <= 1'b0;
        end else begin
            busy_r     <= move_load || (busy_r && !move_done);
            slot_r     <= slot_r == 3'(vdc_pkg::PACE_PERIOD - 1) ? 3'h0 : slot_r + 3'h1;
            rd_pend_r  <= mv_rd_go;
            dac_pend_r <= dac_rd_go;
        end
    end

    block_walker u_src (
        .clk_sys (clk_sys),
        .clr     (vclr),
        .load    (move_load),
        .step    (mv_rd_go),
        .reverse (rev_r),
        .start   (addr_r.src),
        .len     (shape_r.len),
        .lines   (shape_r.lines),
        .skip    (shape_r.skip),
        .addr    (src_addr),
        .active  (src_act)
    );
    block_walker u_dst (
        .clk_sys (clk_sys),
        .clr     (vclr),
        .load    (move_load),
        .step    (mv_wr_go),
        .reverse (rev_r),
        .start   (addr_r.dst),
        .len     (shape_r.len),
        .lines   (shape_r.lines),
        .skip    (shape_r.skip),
        .addr    (dst_addr),
        .active  (dst_act)
    );
    // Room for the read in flight keeps the FIFO from ever refusing a byte
    move_fifo #(.W(vdc_pkg::BYTE_W), .DEPTH(FD)) u_fifo (
        .clk_sys   (clk_sys),
        .clr       (vclr),
        .in_valid  (rd_pend_r),
        .in_ready  (f_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (f_out_valid),
        .out_ready (mem_free),
        .out_data  (f_out_data),
        .level     (f_level)
    );

    // ==========================================
    // Raw sample stream to the DAC
    logic [vdc_pkg::DIV_W-1:0] div_r;
    logic [3:0]                hold_r;
    logic [vdc_pkg::DAC_W-1:0] dac_r;
    wire raw_on     = controller_run_bit && raw_sample_mode_select;
    wire tick       = raw_on && div_r == sample_rate_divider;
    wire idx_last   = idx_r == line_length - 13'h0001;
    wire line_begin = raw_on ? (dac_rd_go && idx_r == '0) : line_start;
    wire hold       = line_begin || hold_r != 4'h0;
    always_ff @(posedge clk_sys) begin
        if (vclr) begin
            div_r      <= '0;
            dac_want_r <= 1'b0;
            idx_r      <= '0;
            hold_r     <= '0;
        end else begin
            div_r      <= (tick || !raw_on) ? '0 : div_r + 4'h1;
            dac_want_r <= raw_on && (tick || (dac_want_r && !dac_rd_go));
            if (!raw_on || (dac_rd_go && idx_last)) begin
                idx_r <= '0;
            end else if (dac_rd_go) begin
                idx_r <= idx_r + 13'h0001;
            end
            hold_r <= line_begin ? 4'(vdc_pkg::HOLD_CYCLES - 1) :
                      (hold_r != 4'h0 ? hold_r - 4'h1 : 4'h0);
        end
    end
    // Pin low clears the DAC side at once, without waiting for a clock
    always_ff @(posedge clk_sys or negedge video_reset_n) begin
        if (!video_reset_n) begin
            dac_r            <= vdc_pkg::DAC_RST;
            modulator_bypass <= 1'b0;
            dac_bias_en      <= 1'b0;
            chroma_u         <= '0;
            chroma_v         <= '0;
        end else if (vclr) begin
            dac_r            <= vdc_pkg::DAC_RST;
            modulator_bypass <= 1'b0;
            dac_bias_en      <= 1'b0;
            chroma_u         <= '0;
            chroma_v         <= '0;
        end else begin
            if (!hold && raw_on && dac_pend_r) begin
                dac_r <= {mem_rd_data, 1'b0};
            end else if (!hold && controller_run_bit && !raw_sample_mode_select) begin
                dac_r <= mod_sample;
            end
            modulator_bypass <= raw_on;
            dac_bias_en      <= analog_bias_on;
            // Table U is always positive: narrower colour space
            chroma_u <= (table_chroma_select && picture_area) ? {2'b00, u_table_bits} :
                        pixel_u;
            chroma_v <= (table_chroma_select && picture_area) ? v_table : pixel_v;
        end
    end
    assign dac_code = dac_r;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (vclr);

    dac_sample_a: assert property (raw_on && dac_pend_r && !hold |=>
        dac_code == {$past(mem_rd_data), 1'b0}) else $error("raw sample not on DAC");
    hold_keep_a: assert property (hold |=> $stable(dac_code))
        else $error("DAC changed during line start hold");
    pace_rate_a: assert property (mv_rd_go [*4] |=> !mv_rd_go)
        else $error("move exceeds four bytes per five cycles");
    host_first_a: assert property (host_mem_busy || disp_fetch_busy |->
        !mem_rd.req && !mem_wr.req) else $error("engine used a busy memory");
    dac_priority_a: assert property (dac_want_r |-> !mv_rd_go)
        else $error("move read beat a raw sample fetch");
    dac_base_a: assert property (dac_rd_go && idx_r == '0 |->
        mem_rd.addr == {buffer_base, 1'b0}) else $error("raw buffer start wrong");
    dac_wrap_a: assert property (dac_rd_go && idx_last |=> idx_r == '0)
        else $error("raw buffer did not wrap at length");
    move_start_a: assert property (move_load && shape_r.len != '0 &&
        shape_r.lines != '0 |=> src_addr == addr_r.src && dst_addr == addr_r.dst)
        else $error("move did not begin at start addresses");
    fifo_safe_a: assert property (rd_pend_r |-> f_in_ready)
        else $error("move byte dropped at full FIFO");
    bypass_a: assert property (raw_on |=> modulator_bypass)
        else $error("modulator not bypassed in raw mode");
    table_u_a: assert property (table_chroma_select && picture_area |=>
        chroma_u == {2'b00, $past(u_table_bits)}) else $error("table U not used");

    move_end_c: cover property (busy_r ##1 !busy_r);
    dac_wrap_c: cover property (dac_rd_go && idx_last);
    host_stall_c: cover property (src_act && host_mem_busy);
endmodule // vdc_mem_engines
`default_nettype wire

// >>> rtl/vdc_pkg.sv
`default_nettype none
package vdc_pkg;
    // ==========================================
    // Widths
    localparam int ADDR_W            = 17;
    localparam int LEN_W             = 8;
    localparam int LINES_W           = 9;
    localparam int SKIP_W            = 12;
    localparam int DIV_W             = 4;
    localparam int BASE_W            = 16;
    localparam int LLEN_W            = 13;
    localparam int DAC_W             = 9;
    localparam int BYTE_W            = 8;
    // ==========================================
    // Timing, in video pixel clock cycles, plus move pace byte count and FIFO depth
    localparam int HOLD_CYCLES       = 10;
    localparam int RESET_EXIT_CYCLES = 3;
    localparam int PACE_PERIOD       = 5;
    localparam int PACE_BYTES        = 4;
    localparam int FIFO_DEPTH        = 16;
    // ==========================================
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DAC_W-1:0]  DAC_RST  = 9'h000;
    // ==========================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } move_addr_t;
    typedef struct packed {
        logic [LEN_W-1:0]   len;
        logic [LINES_W-1:0] lines;
        logic [SKIP_W-1:0]  skip;
    } move_shape_t;
    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
    } mem_rd_t;
    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } mem_wr_t;
endpackage
`default_nettype wire

// >>> tb/vdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Byte memory behind the engines
module vdc_mem_model (
    input  wire logic                  clk_sys,
    input  wire vdc_pkg::mem_rd_t      mem_rd,
    input  wire vdc_pkg::mem_wr_t      mem_wr,
    output logic [vdc_pkg::BYTE_W-1:0] mem_rd_data
);
    logic [7:0] mem [0:131071];
    initial begin
        for (int a = 0; a < 131072; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 9);
        end
        mem_rd_data = 8'h00;
    end
    // Answers every cycle, so only the engine sets the pace
    always @(posedge clk_sys) begin
        if (mem_wr.req === 1'b1) begin
            mem[mem_wr.addr] <= mem_wr.data;
        end
        // Idle bus inverts its last output each cycle, so it alternates with a stale copy
        if (mem_rd.req === 1'b1) begin
            mem_rd_data <= mem[mem_rd.addr];
        end else begin
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule // vdc_mem_model
`default_nettype wire

// >>> tb/video_block_move_and_direct_dac_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module video_block_move_and_direct_dac_tb_top;
    logic clk_sys, rst, vrn, aw, sw, rev, start, hb, db, run, raw, bias, ls, tsel, parea;
    logic busy, byp, ben;
    vdc_pkg::move_addr_t  ap;
    vdc_pkg::move_shape_t sp;
    vdc_pkg::mem_rd_t     rd;
    vdc_pkg::mem_wr_t     wr;
    logic [3:0]  div, utb, vtb, pv, cv;
    logic [15:0] base;
    logic [12:0] llen;
    logic [8:0]  mods, dac;
    logic [7:0]  rdd;
    logic [5:0]  pu, cu;
    int n_mismatch, checks, n_wr, n_rd, n_bad;
    // ==========================================
    // Design and memory
    vdc_mem_engines dut (.clk_sys(clk_sys), .rst(rst), .video_reset_n(vrn),
        .move_address_param_write(aw), .move_addr_param(ap), .move_shape_param_write(sw),
        .move_shape_param(sp), .move_reverse(rev), .move_start(start), .move_busy(busy),
        .host_mem_busy(hb), .disp_fetch_busy(db), .mem_rd(rd), .mem_rd_data(rdd), .mem_wr(wr),
        .controller_run_bit(run), .raw_sample_mode_select(raw), .analog_bias_on(bias),
        .sample_rate_divider(div), .buffer_base(base), .line_length(llen), .line_start(ls),
        .mod_sample(mods), .modulator_bypass(byp), .dac_bias_en(ben), .dac_code(dac),
        .table_chroma_select(tsel), .picture_area(parea), .u_table_bits(utb),
        .v_table(vtb), .pixel_u(pu), .pixel_v(pv), .chroma_u(cu), .chroma_v(cv));
    vdc_mem_model mem (.clk_sys(clk_sys), .mem_rd(rd), .mem_wr(wr), .mem_rd_data(rdd));
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (wr.req === 1'b1) n_wr++;
        if (rd.req === 1'b1) n_rd++;
        if ((hb || db) && (rd.req === 1'b1 || wr.req === 1'b1)) n_bad++;
    end
    // ==========================================
    // Helpers
    function automatic logic [7:0] pat(input logic [16:0] a);
        return a[7:0] ^ a[16:9];
    endfunction
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_move(input logic r, input logic [16:0] s, input logic [16:0] d,
                          input int ln, input int nl, input int sk, input int cmax);
        int w0, k, l, i, off;
        w0 = n_wr;
        ap = '{src: s, dst: d};
        aw = 1'b1;
        tick();
        aw = 1'b0;
        sp = '{len: ln[7:0], lines: nl[8:0], skip: sk[11:0]};
        sw = 1'b1;
        tick();
        sw = 1'b0;
        rev = r;
        start = 1'b1;
        tick();
        start = 1'b0;
        chk("busy_after_start", 1, busy);
        hb = (cmax == 0);
        db = (cmax == 0);
        for (k = 0; k < 12; k++) begin
            start = (k == 5);
            tick();
        end
        hb = 1'b0;
        db = 1'b0;
        start = 1'b0;
        for (k = 13; busy !== 1'b0; k++) begin
            if (k > 3000) begin
                n_mismatch++;
                end_sim();
            end
            tick();
        end
        if (cmax > 0) chk("move_pace", 1, k <= cmax);
        chk("write_count", ln * nl, n_wr - w0);
        chk("stall_access", 0, n_bad);
        for (l = 0; l < nl; l++) begin
            for (i = 0; i < ln; i++) begin
                off = r ? -(l * sk + i) : l * sk + i;
                chk("moved_byte", pat(s + off), mem.mem[d + off]);
            end
        end
        chk("byte_past_line", pat(r ? d - ln : d + ln), mem.mem[r ? d - ln : d + ln]);
        $display("move test done");
    endtask
    task automatic t_raw();
        logic [1:0] seen;
        int oth, bad, k, p, q, r0;
        // Pass of 20 cycles: samples 0 and 1 fall inside the line-start hold
        base = 16'h0800;
        llen = 13'h0004;
        div = 4'h4;
        raw = 1'b1;
        bias = 1'b1;
        tick();
        run = 1'b1;
        for (p = 0; p < 2; p++) begin
            seen = 2'b00;
            oth = 0;
            bad = 0;
            for (k = 0; k < 80; k++) begin
                tick();
                if (rd.req === 1'b1 && (rd.addr < 17'h01000 || rd.addr > 17'h01003)) bad++;
                for (q = 2; q < 4; q++) begin
                    if (dac === {pat(17'h01000 + q), 1'b0}) seen[q-2] = 1'b1;
                end
                if (dac[0] !== 1'b0) oth++;
            end
            chk("raw_samples_seen", 2'b11, seen);
            chk("raw_fetch_range", 0, bad);
            chk("dac_lsb_zero", 0, oth);
            chk("mod_bypass", 1, byp);
            chk("bias_on", 1, ben);
            if (p == 0) begin
                vrn = 1'b0;
                #2;
                chk("dac_in_reset", 9'h000, dac);
                chk("bypass_in_reset", 0, byp);
                tick();
                tick();
                vrn = 1'b1;
                r0 = n_rd;
                tick();
                tick();
                chk("reads_in_exit", 0, n_rd - r0);
            end
        end
        run = 1'b0;
        raw = 1'b0;
        $display("raw test done");
    endtask
    task automatic t_hold();
        run = 1'b1;
        mods = 9'h055;
        // Let a hold left over from the raw test run out first
        repeat (12) tick();
        chk("video_copy", 9'h055, dac);
        ls = 1'b1;
        mods = 9'h1AA;
        tick();
        ls = 1'b0;
        repeat (7) tick();
        chk("dac_held", 9'h055, dac);
        repeat (5) tick();
        chk("dac_after_hold", 9'h1AA, dac);
        run = 1'b0;
        $display("hold test done");
    endtask
    task automatic t_chroma();
        tsel = 1'b1;
        parea = 1'b1;
        repeat (2) tick();
        chk("table_u", 6'h0A, cu);
        chk("table_v", 4'h5, cv);
        parea = 1'b0;
        repeat (2) tick();
        chk("border_u", 6'h3F, cu);
        tsel = 1'b0;
        parea = 1'b1;
        repeat (2) tick();
        chk("pixel_v", 4'h3, cv);
        $display("chroma test done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {rst, vrn} = 2'b11;
        {aw, sw, rev, start, hb, db, run, raw, bias, ls, tsel, parea} = 12'h000;
        ap = '0;
        sp = '0;
        div = 4'h0;
        base = 16'h0001;
        llen = 13'h0001;
        mods = 9'h000;
        utb = 4'hA;
        vtb = 4'h5;
        pu = 6'h3F;
        pv = 4'h3;
        {n_mismatch, checks, n_wr, n_rd, n_bad} = '0;
        clk_sys = 1'b0;
        repeat (20) tick();
        rst = 1'b0;
        tick();
        // Odd destinations keep line ends off word boundaries
        t_move(1'b0, 17'h01001, 17'h02003, 5, 3, 16, 40);
        t_move(1'b1, 17'h03100, 17'h04101, 4, 2, 9, 0);
        t_move(1'b0, 17'h05000, 17'h06001, 0, 4, 1, 20);
        t_move(1'b0, 17'h08000, 17'h0A001, 2, 256, 3, 700);
        t_raw();
        t_hold();
        t_chroma();
        end_sim();
    end
endmodule // video_block_move_and_direct_dac_tb_top
`default_nettype wire
